/* File: logic/msd_decoder.sv */
// Functional notes
// - Decode a 20-bit, one-megabyte unified address space.
// - Program memory placement follows the sampled program-source select level.
// - Select high fetches from internal ROM, low fetches from the external bus.
// - Full-ROM variant with internal program maps 00000h-03fffh to internal ROM.
// - Full-ROM variant with internal program maps 04000h-0fcffh to external memory only in expansion mode.
// - Reduced-ROM maps ROM to 00000h-01fffh and 02000h-0fd7fh external in expansion mode.
// - ROM-less variant sends 00000h-0fcffh to external memory.
// - Data reads and writes may also target the external program region.
// - Full-ROM and ROM-less variants decode 0fd00h-0feffh as internal RAM.
// - Reduced-ROM variant decodes only 0fd80h-0feffh as internal RAM.
// - In one-megabyte mode, data accesses 10000h-fffffh go external.
// - Upper-address pins float during reset and drive low after release.
// - 0ff00h-0ffffh decodes as the special-function region.
// - In one-megabyte mode the upper-address pins carry address bits 16 to 19.
`timescale 1ns/1ps
`default_nettype none
`include "msd_params.svh"
module msd_decoder
  import msd_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire msd_variant_t variant,
  input wire logic program_source_select,
  input wire logic ext_expansion_mode,
  input wire logic mbyte_expansion_mode,
  input wire logic access_valid,
  input wire logic access_fetch,
  input wire logic access_write,
  input wire logic [`MSD_ADDR_W-1:0] access_addr,
  output logic sel_rom,
  output logic sel_ram,
  output logic sel_sfr,
  output logic sel_ext,
  output logic access_fault,
  output logic ext_write,
  output logic [`MSD_ADDR_W-1:0] ext_addr,
  output logic [3:0] upper_address_pins_out,
  output logic [3:0] upper_address_pins_oe
);
  logic src_internal;
  logic pins_live;
  logic next_pins_live;
  logic [3:0] next_upper;
  logic [3:0] upper_q;
  logic upper_hit;
  logic low_ram;
  logic low_sfr;
  logic low_rom;
  logic low_ext;
  msd_region_t region;
  logic [`MSD_ADDR_W-1:0] next_ext_addr;
  logic next_ext_write;
  logic hit_ram_full;
  logic hit_ram_red;
  logic hit_rom_full;
  logic hit_rom_red;
  logic hit_ext_full;
  logic hit_ext_red;
  logic hit_low_full;
  logic hit_low_red;
  logic upper_ok;
  logic rom_ok;
  logic [3:0] bank_bits;

  // Pin level crosses in from outside, so synchronise before use
  // A select change takes two edges to reach the decode
  msd_sync u_src_sync (
    .clock(clock),
    .arst_n(arst_n),
    .din(program_source_select),
    .dout(src_internal)
  );

  // Every window is compared once; the variant only picks among them
  always_comb begin
    // No upper bound needed: twenty bits end at the top of the space
    upper_hit = (access_addr >= `MSD_EXP_LO);
    low_sfr = (access_addr >= `MSD_SFR_LO) && (access_addr <= `MSD_SFR_HI);
    hit_ram_full = (access_addr >= `MSD_RAM_FULL_LO) && (access_addr <= `MSD_RAM_HI);
    hit_ram_red = (access_addr >= `MSD_RAM_RED_LO) && (access_addr <= `MSD_RAM_HI);
    hit_rom_full = (access_addr <= `MSD_ROM_FULL_TOP);
    hit_rom_red = (access_addr <= `MSD_ROM_RED_TOP);
    hit_ext_full = (access_addr >= `MSD_EXT_FULL_LO) && (access_addr <= `MSD_EXT_FULL_HI);
    hit_ext_red = (access_addr >= `MSD_EXT_RED_LO) && (access_addr <= `MSD_EXT_RED_HI);
    // Select low hands the whole low program area to the external bus
    hit_low_full = (access_addr <= `MSD_EXT_FULL_HI);
    hit_low_red = (access_addr <= `MSD_EXT_RED_HI);
  end

  // Window choice per variant; code 3 behaves as the full-ROM part
  always_comb begin
    low_ram = 1'b0;
    low_rom = 1'b0;
    low_ext = 1'b0;
    unique case (variant)
      MSD_VAR_REDUCED_ROM: begin
        // Reduced part: RAM starts later, ROM ends earlier
        low_ram = hit_ram_red;
        if (src_internal) begin
          low_rom = hit_rom_red;
          low_ext = ext_expansion_mode && hit_ext_red;
        end else begin
          low_ext = hit_low_red;
        end
      end
      MSD_VAR_ROMLESS: begin
        // No internal ROM on this part
        low_ram = hit_ram_full;
        low_ext = hit_low_full;
      end
      default: begin
        low_ram = hit_ram_full;
        if (src_internal) begin
          low_rom = hit_rom_full;
          low_ext = ext_expansion_mode && hit_ext_full;
        end else begin
          low_ext = hit_low_full;
        end
      end
    endcase
  end

  // Upper space is data only; fetches there are refused
  always_comb begin
    upper_ok = mbyte_expansion_mode && !access_fetch;
    // Internal ROM is read only, writes fall through to fault
    rom_ok = !access_write;
  end

  // Priority chain guarantees a single select
  always_comb begin
    region = MSD_REG_NONE;
    if (!access_valid) begin
      region = MSD_REG_NONE;
    end else if (upper_hit) begin
      if (upper_ok) begin
        region = MSD_REG_EXT;
      end
    end else if (low_ram) begin
      // RAM sits above the low program area, so no window of that area overlaps it
      region = MSD_REG_RAM;
    end else if (low_sfr) begin
      region = MSD_REG_SFR;
    end else if (low_rom) begin
      if (rom_ok) begin
        region = MSD_REG_ROM;
      end
    end else if (low_ext) begin
      region = MSD_REG_EXT;
    end
  end

  // One-hot by construction of the region code
  always_comb begin
    sel_rom = (region == MSD_REG_ROM);
    sel_ram = (region == MSD_REG_RAM);
    sel_sfr = (region == MSD_REG_SFR);
    sel_ext = (region == MSD_REG_EXT);
    access_fault = access_valid && (region == MSD_REG_NONE);
  end

  // Pin enable group
  always_comb begin
    next_pins_live = 1'b1;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pins_live <= 1'b0;
    end else begin
      pins_live <= next_pins_live;
    end
  end

  // External address group holds the last external access
  // Held rather than cleared so the bus controller sees stable lines
  always_comb begin
    next_ext_addr = sel_ext ? access_addr : ext_addr;
    next_ext_write = sel_ext ? access_write : ext_write;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ext_addr <= '0;
      ext_write <= 1'b0;
    end else begin
      ext_addr <= next_ext_addr;
      ext_write <= next_ext_write;
    end
  end

  // Bank group; an external access outside one-megabyte mode loads a zero bank
  always_comb begin
    bank_bits = access_addr[`MSD_UPPER_LSB +: 4];
    next_upper = upper_q;
    if (sel_ext) begin
      next_upper = mbyte_expansion_mode ? bank_bits : 4'h0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      upper_q <= 4'h0;
    end else begin
      upper_q <= next_upper;
    end
  end

  // Floats in reset, low afterwards until an expanded access
  // Bank pins have no pull; keep them driven whenever out of reset
  for (genvar b = 0; b < 4; b++) begin : g_pin
    assign upper_address_pins_oe[b] = pins_live;
    assign upper_address_pins_out[b] = upper_q[b];
  end
endmodule : msd_decoder
`default_nettype wire

/* File: logic/msd_params.svh */
`ifndef MSD_PARAMS_SVH
`define MSD_PARAMS_SVH
`define MSD_ADDR_W 20
`define MSD_ROM_FULL_TOP 20'h03fff
`define MSD_EXT_FULL_LO 20'h04000
`define MSD_EXT_FULL_HI 20'h0fcff
`define MSD_ROM_RED_TOP 20'h01fff
`define MSD_EXT_RED_LO 20'h02000
`define MSD_EXT_RED_HI 20'h0fd7f
`define MSD_RAM_FULL_LO 20'h0fd00
`define MSD_RAM_RED_LO 20'h0fd80
`define MSD_RAM_HI 20'h0feff
`define MSD_SFR_LO 20'h0ff00
`define MSD_SFR_HI 20'h0ffff
`define MSD_EXP_LO 20'h10000
`define MSD_EXP_HI 20'hfffff
`define MSD_UPPER_LSB 16
`endif

/* File: logic/msd_pkg.sv */
package msd_pkg;
  typedef enum logic [1:0] {
    MSD_VAR_FULL_ROM,
    MSD_VAR_REDUCED_ROM,
    MSD_VAR_ROMLESS
  } msd_variant_t;
  typedef enum logic [2:0] {
    MSD_REG_NONE,
    MSD_REG_ROM,
    MSD_REG_RAM,
    MSD_REG_SFR,
    MSD_REG_EXT
  } msd_region_t;
endpackage : msd_pkg

/* File: logic/msd_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module msd_sync (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic din,
  output logic dout
);
  logic stage1;
  logic next_stage1;
  logic next_dout;
  always_comb begin
    next_stage1 = din;
    next_dout = stage1;
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= 1'b0;
      dout <= 1'b0;
    end else begin
      stage1 <= next_stage1;
      dout <= next_dout;
    end
  end
endmodule : msd_sync
`default_nettype wire

/* File: verif/msd_decoder_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module msd_decoder_monitor (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [19:0] access_addr,
  input wire logic sel_rom,
  input wire logic sel_ram,
  input wire logic sel_sfr,
  input wire logic sel_ext,
  input wire logic [3:0] upper_address_pins_out,
  input wire logic [3:0] upper_address_pins_oe
);
  wire logic [19:0] a = access_addr;
  wire logic [3:0] oe = upper_address_pins_oe;
  wire logic [3:0] sel = {sel_rom, sel_ram, sel_sfr, sel_ext};
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence s_bank; ##1 upper_address_pins_out == $past(a[19:16]); endsequence
  sel_one_a: assert property ($onehot0(sel)) else $error("two selects");
  sfr_span_a: assert property (sel_sfr |-> a[19:8] == 12'h0ff) else $error("sfr");
  ram_span_a: assert property (sel_ram |-> a inside {[20'h0fd00:20'h0feff]})
    else $error("ram");
  rom_span_a: assert property (sel_rom |-> a <= 20'h03fff) else $error("rom");
  upper_ext_a: assert property (|a[19:16] |-> sel[3:1] == 3'h0) else $error("upper");
  bank_drive_a: assert property (sel_ext && |a[19:16] |-> s_bank) else $error("bank");
  pins_float_a: assert property (disable iff (1'b0) !arst_n |-> oe == 4'h0)
    else $error("float");
  pins_drive_a: assert property ($past(arst_n) |-> oe == 4'hf) else $error("drive");
endmodule : msd_decoder_monitor
bind msd_decoder msd_decoder_monitor u_mon (.*);
`default_nettype wire

/* File: verif/msd_ext_model.sv */
`timescale 1ns/1ps
`default_nettype none
module msd_ext_model (
  input wire logic [19:0] ext_addr,
  input wire logic [3:0] upper_address_pins_out,
  input wire logic [3:0] upper_address_pins_oe,
  output logic [19:0] bus_addr
);
  // No pull on the bank pins, so a released pin reads back inverted
  assign bus_addr = {~(upper_address_pins_out ^ upper_address_pins_oe),
    ext_addr[15:0]};
endmodule : msd_ext_model
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import msd_pkg::*;
  logic clock = '0, arst_n = '1, program_source_select = '0, ext_expansion_mode = '0;
  logic mbyte_expansion_mode = '0, access_valid = '0, access_fetch = '0, access_write = '0;
  logic sel_rom, sel_ram, sel_sfr, sel_ext, access_fault, ext_write, e_wr, s1, s2;
  logic [19:0] access_addr = '0, ext_addr, bus_addr, e_a;
  logic [3:0] upper_address_pins_out, upper_address_pins_oe, e_p;
  logic [31:0] rng = 32'h32;
  logic [4:0] w;
  msd_variant_t variant = MSD_VAR_FULL_ROM;
  int num_errors, n_checks, cyc, run;
  msd_decoder u_dut (.*);
  msd_ext_model u_ext (.*);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic chk(input logic [24:0] seen, input logic [24:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  function automatic logic [4:0] want(input logic [19:0] a, input logic ps);
    logic red;
    logic nr;
    red = variant == MSD_VAR_REDUCED_ROM;
    nr = variant == MSD_VAR_ROMLESS || !ps;
    if (!access_valid) return 5'h00;
    if (a[19:16] != 4'h0) return access_fetch || !mbyte_expansion_mode ? 5'h01 : 5'h02;
    if (a >= 20'h0ff00) return 5'h04;
    if (a >= (red ? 20'h0fd80 : 20'h0fd00)) return 5'h08;
    if (!nr && a <= (red ? 20'h01fff : 20'h03fff)) return access_write ? 5'h01 : 5'h10;
    return nr || ext_expansion_mode ? 5'h02 : 5'h01;
  endfunction : want
  // Select pin is seen two edges late, as the synchroniser delivers it
  always @(negedge clock) begin
    if (!arst_n) begin
      chk(25'(upper_address_pins_oe), 25'h0, "oe");
      {s1, s2, e_wr, e_a, e_p, run} = '0;
    end else begin
      if (run++ > 0) begin
        chk({ext_write, upper_address_pins_oe, bus_addr},
            {e_wr, 4'hf, e_p, e_a[15:0]}, "ext");
        chk(25'(ext_addr), 25'(e_a), "addr");
      end
      w = want(access_addr, s2);
      chk(25'({sel_rom, sel_ram, sel_sfr, sel_ext, access_fault}), 25'(w), "sel");
      if (w == 5'h02) begin
        {e_wr, e_a} = {access_write, access_addr};
        e_p = mbyte_expansion_mode ? access_addr[19:16] : 4'h0;
      end
      {s2, s1} = {s1, program_source_select};
    end
  end
  initial forever #5 clock = ~clock;
  always @(posedge clock) if (++cyc == 4000) begin
    num_errors++;
    report_and_stop();
  end
  initial begin
    #1 arst_n = '0;
    repeat (20) @(posedge clock);
    arst_n <= '1;
    for (int v = 0; v < 3; v++) begin
      variant <= msd_variant_t'(v);
      repeat (600) begin
        @(posedge clock);
        rng = xs(rng);
        access_valid <= |rng[1:0];
        {access_fetch, mbyte_expansion_mode, ext_expansion_mode} <= rng[4:2];
        access_write <= rng[5] & ~rng[4];
        program_source_select <= |rng[7:6];
        access_addr <= {rng[8] ? rng[31:28] : 4'h0, rng[9] ? 4'hf : rng[27:24], rng[23:12]};
      end
    end
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
